// ### design/dcs_pkg.sv
// Purpose: shared constants for the crc seed and tap block
// Assumes: 32-bit classic wishbone register access
// Notes: offsets are byte addresses
package dcs_pkg;
	localparam logic [3:0] DCS_OFF_CTRL = 4'h0;
	localparam logic [3:0] DCS_OFF_VALUE = 4'h4;
	localparam logic [3:0] DCS_OFF_TAPS = 4'h8;
	localparam logic [3:0] DCS_OFF_DATA = 4'hc;
	localparam int DCS_TYPE_BIT = 15;
	localparam int DCS_POLYNOMIAL_LENGTH_LSB = 0;
	localparam int DCS_POLYNOMIAL_LENGTH_W = 5;
	localparam logic [31:0] DCS_VALUE_RST = 32'h00000000;
	localparam logic [31:0] DCS_TAPS_RST = 32'h00000000;
	localparam logic [31:0] DCS_CTRL_RST = 32'h00000000;
	localparam int DCS_CSUM_W = 16;
	localparam int DCS_BYTE_BITS = 8;
	typedef enum logic [1:0] {
		DCS_IDLE = 2'b00,
		DCS_SHIFT = 2'b01,
		DCS_ACK = 2'b10
	} dcs_state_t;
endpackage

// ### design/dcs_lfsr_step.sv
// Purpose: one bit step of the crc shift register, taken only while a byte shifts
// Assumes: polynomial_length_i is polynomial length minus one
// Notes: purely combinational
`timescale 1ns/100ps
module dcs_lfsr_step #(
	parameter int W = 32
) (
	// state in and out
	input wire logic [W-1:0] crc_i,
	input wire logic [W-1:0] taps_i,
	input wire logic [4:0] polynomial_length_i,
	input wire logic bit_i,
	output logic [W-1:0] crc_o
);
	logic fb;
	always_comb begin
		fb = crc_i[polynomial_length_i] ^ bit_i;
		crc_o = '0;
		for (int n = 0; n < W; n++) begin
			if (n == 0) begin
				crc_o[n] = taps_i[n] ? fb : bit_i;
			end else begin
				crc_o[n] = taps_i[n] ? (crc_i[n-1] ^ fb) : crc_i[n-1];
			end
		end
	end
endmodule

// ### design/dcs_crc_regs.sv
// Purpose: seed, readback and feedback taps of a dma crc engine
// Assumes: classic wishbone slave, single clock, synchronous reset
// Notes: data bytes arrive on a valid/ready stream, lsb first;
//  a pending bus access always wins over a waiting byte;
//  in shift mode a byte holds off the bus for eight clocks
//
// Overview of operation
// - writing the value register seeds the generator
// - reading the value register returns the running crc
// - shift mode masks value bits above the polynomial length
// - checksum mode keeps 16 low bits, upper bits read zero
// - checksum mode stores written value complemented and reads it back as written
// - control bit 15 picks checksum mode when set
// - checksum mode ignores the tap register
// - tap one xors feedback into a stage, zero passes through
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module dcs_crc_regs #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// byte stream from the dma path
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready
);
	// ****************************************
	// state record
	// ****************************************
	// one record keeps reset and next state in step;
	// a new field cannot be missed in either place
	typedef struct packed {
		dcs_pkg::dcs_state_t st;
		logic [31:0] ctrl;
		logic [31:0] value;
		logic [31:0] taps;
		logic [7:0] shreg;
		logic [2:0] cnt;
		logic [31:0] rdat;
		logic ack;
		logic hi_half;
	} dcs_regs_t;

	dcs_regs_t s_q, s_d;
	logic [W-1:0] step_out;
	logic csum_mode;
	logic [4:0] polynomial_length;
	logic [31:0] len_mask;
	logic [31:0] wmask;
	logic bus_req;
	logic [16:0] csum_sum;
	logic [15:0] csum_word;
	logic [15:0] csum_seed;

	// ****************************************
	// mode and length decode
	// ****************************************
	// mode from control bit
	assign csum_mode = s_q.ctrl[dcs_pkg::DCS_TYPE_BIT];
	assign polynomial_length = s_q.ctrl[dcs_pkg::DCS_POLYNOMIAL_LENGTH_LSB +: dcs_pkg::DCS_POLYNOMIAL_LENGTH_W];
	// a raised ack masks the held strobe from a second take
	assign bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// lanes merge in the form software reads, else unselected
	// checksum lanes would flip on the next readback
	assign csum_seed = ~((~s_q.value[15:0] & ~wmask[15:0]) |
		(wb_dat_i[15:0] & wmask[15:0]));

	always_comb begin
		len_mask = '0;
		for (int i = 0; i < 32; i++) begin
			len_mask[i] = (i <= int'(polynomial_length));
		end
	end

	// ****************************************
	// shift step
	// ****************************************
	// a short polynomial leaves the upper taps idle
	// checksum path never sees taps
	dcs_lfsr_step #(
		.W(W)
	) u_step (
		.crc_i(s_q.value[W-1:0]),
		.taps_i(s_q.taps[W-1:0] & len_mask[W-1:0]),
		.polynomial_length_i(polynomial_length),
		.bit_i(s_q.shreg[0]),
		.crc_o(step_out)
	);

	// ****************************************
	// checksum adder
	// ****************************************
	// first byte of a pair is the high one; an odd byte stays padded
	// ones-complement add of a 16-bit word; bytes pair big endian
	always_comb begin
		csum_word = s_q.hi_half ? {8'h00, byte_data} : {byte_data, 8'h00};
		csum_sum = {1'b0, s_q.value[15:0]} + {1'b0, csum_word};
	end

	// ****************************************
	// bus and stream control
	// ****************************************
	// the stream stalls for a bus request; the bus waits only while a byte shifts
	assign byte_ready = (s_q.st == dcs_pkg::DCS_IDLE) & ~bus_req;

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		case (s_q.st)
			dcs_pkg::DCS_IDLE: begin
				if (bus_req) begin
					s_d.st = dcs_pkg::DCS_ACK;
					s_d.ack = 1'b1;
					s_d.rdat = 32'h00000000;
					case (wb_adr_i)
						dcs_pkg::DCS_OFF_CTRL: begin
							s_d.rdat = s_q.ctrl;
							if (wb_we_i) begin
								s_d.ctrl = (s_q.ctrl & ~wmask) |
									(wb_dat_i & wmask);
							end
						end
						dcs_pkg::DCS_OFF_VALUE: begin
							if (csum_mode) begin
								s_d.rdat = {16'h0000, ~s_q.value[15:0]};
							end else begin
								s_d.rdat = s_q.value & len_mask;
							end
							if (wb_we_i) begin
								if (csum_mode) begin
									s_d.value = {16'h0000, csum_seed};
								end else begin
									s_d.value = (s_q.value & ~wmask) |
										(wb_dat_i & wmask);
								end
								s_d.hi_half = 1'b0;
							end
						end
						dcs_pkg::DCS_OFF_TAPS: begin
							s_d.rdat = s_q.taps;
							if (wb_we_i) begin
								s_d.taps = (s_q.taps & ~wmask) |
									(wb_dat_i & wmask);
							end
						end
						default: begin
							s_d.rdat = 32'h00000000;
						end
					endcase
				end else if (byte_valid) begin
					if (csum_mode) begin
						// end-around carry folded back in
						s_d.value = {16'h0000,
							csum_sum[15:0] + {15'h0000, csum_sum[16]}};
						s_d.hi_half = ~s_q.hi_half;
					end else begin
						s_d.shreg = byte_data;
						s_d.cnt = 3'h0;
						s_d.st = dcs_pkg::DCS_SHIFT;
					end
				end
			end
			dcs_pkg::DCS_SHIFT: begin
				// one stage shift per clock
				// re-mask so stale high bits never feed back
				s_d.value = step_out & len_mask;
				s_d.shreg = {1'b0, s_q.shreg[7:1]};
				s_d.cnt = s_q.cnt + 3'h1;
				if (s_q.cnt == 3'h7) begin
					s_d.st = dcs_pkg::DCS_IDLE;
				end
			end
			dcs_pkg::DCS_ACK: begin
				s_d.st = dcs_pkg::DCS_IDLE;
			end
			default: begin
				s_d.st = dcs_pkg::DCS_IDLE;
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// clear first so fields without a reset constant are defined
			s_q <= '0;
			s_q.ctrl <= dcs_pkg::DCS_CTRL_RST;
			s_q.value <= dcs_pkg::DCS_VALUE_RST;
			s_q.taps <= dcs_pkg::DCS_TAPS_RST;
			s_q.st <= dcs_pkg::DCS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
endmodule

// ### verification/dcs_crc_regs_sva.sv
// Purpose: bus and readback checks
// Assumes: seed shadow trusted only after full-word writes
// Notes: shadows keep what software wrote
`timescale 1ns/100ps
module dcs_crc_regs_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// byte stream
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic byte_ready
);
logic [31:0] ctl_q, val_q, tap_q;
logic new_q;
wire wr = wb_ack_o & wb_we_i;
wire rv = wb_ack_o & !wb_we_i & (wb_adr_i == dcs_pkg::DCS_OFF_VALUE);
wire wv = wr & (wb_adr_i == dcs_pkg::DCS_OFF_VALUE);
wire wc = wr & (wb_adr_i == dcs_pkg::DCS_OFF_CTRL);
wire wt = wr & (wb_adr_i == dcs_pkg::DCS_OFF_TAPS);
wire [31:0] wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
wire [31:0] msk = ~(32'hffffffff << (ctl_q[4:0] + 6'h1));
// a taken byte makes the seed stale
always_ff @(posedge ref_clk) begin
	if (sys_rst) begin
		ctl_q <= '0;
		val_q <= '0;
		tap_q <= '0;
		new_q <= 1'h0;
	end else begin
		if (wc) ctl_q <= (ctl_q & ~wm) | (wb_dat_i & wm);
		if (wt) tap_q <= (tap_q & ~wm) | (wb_dat_i & wm);
		if (wv) val_q <= wb_dat_i;
		// a byte-lane write leaves lanes the shadow never saw
		new_q <= (wv & (&wb_sel_i)) |
			(new_q & !(byte_valid & byte_ready) & !wc & !wv);
	end
end
default clocking @(posedge ref_clk); endclocking
default disable iff (sys_rst);
AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
	else $error("ack longer than one cycle");
AST_ACK_REQ: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
	else $error("ack without request");
AST_ACK_SOON: assert property ($rose(wb_cyc_i & wb_stb_i) |-> ##[1:9] wb_ack_o)
	else $error("ack late");
AST_SEED_LFSR: assert property (
	rv && !ctl_q[15] && new_q |-> wb_dat_o == (val_q & msk))
	else $error("seed not read back");
AST_SEED_CSUM: assert property (
	rv && ctl_q[15] && new_q |-> wb_dat_o == {16'h0, val_q[15:0]})
	else $error("checksum seed wrong");
AST_UPPER_ZERO: assert property (rv && ctl_q[15] |-> wb_dat_o[31:16] == 16'h0)
	else $error("upper half not zero");
AST_LEN_MASK: assert property (rv && !ctl_q[15] |-> (wb_dat_o & ~msk) == '0)
	else $error("bits above length set");
AST_TAPS_RB: assert property (
	wb_ack_o && !wb_we_i && wb_adr_i == dcs_pkg::DCS_OFF_TAPS |-> wb_dat_o == tap_q)
	else $error("taps readback wrong");
AST_BUS_FIRST: assert property (
	wb_cyc_i && wb_stb_i && !wb_ack_o |-> !byte_ready)
	else $error("byte taken during a bus request");
AST_SHIFT_BUSY: assert property (
	byte_valid && byte_ready && !ctl_q[15] |=> !byte_ready [*8])
	else $error("byte taken while shifting");
endmodule
bind dcs_crc_regs dcs_crc_regs_sva chk_u (.ref_clk, .sys_rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .byte_valid, .byte_ready, .byte_data);

// ### verification/test_dcs_crc_regs.sv
// Purpose: directed bench for the crc seed block
// Assumes: one bus request at a time
// Notes: crc model is bit serial, lsb first
`timescale 1ns/100ps
module test_dcs_crc_regs;
localparam logic [3:0] va = dcs_pkg::DCS_OFF_VALUE;
localparam logic [3:0] ta = dcs_pkg::DCS_OFF_TAPS;
localparam logic [3:0] ct = dcs_pkg::DCS_OFF_CTRL;
logic ref_clk = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
logic wb_we_i = 1'h0, byte_valid = 1'h0, wb_ack_o, byte_ready;
logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
logic [7:0] byte_data = 8'h0;
int errors = 0, n_compared = 0, cyc_n = 0;
dcs_crc_regs dut_u (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .byte_valid,
	.byte_data, .byte_ready);
initial forever #2.5 ref_clk = ~ref_clk;
task automatic give_verdict;
	$display("errors %0d compared %0d", errors, n_compared);
	if (errors == 0 && n_compared > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
always @(posedge ref_clk) begin
	cyc_n <= cyc_n + 1;
	if (cyc_n == 3000) begin
		errors++;
		give_verdict();
	end
end
task automatic chk(input logic [31:0] got, exp);
	n_compared++;
	if (got !== exp) begin
		errors++;
		$display("Error %0t: got %h want %h", $time, got, exp);
	end
endtask
task automatic bus_s(input logic w, input logic [3:0] a, input logic [31:0] d,
	input logic [3:0] s);
	wb_cyc_i <= 1'h1;
	wb_stb_i <= 1'h1;
	wb_we_i <= w;
	wb_sel_i <= s;
	wb_adr_i <= a;
	wb_dat_i <= d;
	do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
	rd_q = wb_dat_o;
	wb_cyc_i <= 1'h0;
	wb_stb_i <= 1'h0;
	@(posedge ref_clk);
endtask
task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
	bus_s(w, a, d, 4'hf);
endtask
task automatic rdc(input logic [3:0] a, input logic [31:0] e);
	bus(1'h0, a, 32'h0);
	chk(rd_q, e);
endtask
task automatic put(input logic [7:0] b);
	byte_valid <= 1'h1;
	byte_data <= b;
	do @(posedge ref_clk); while (byte_ready !== 1'h1);
	byte_valid <= 1'h0;
	repeat (10) @(posedge ref_clk);
endtask
function automatic logic [31:0] step(logic [31:0] c, t, logic [7:0] b);
	logic fb;
	for (int i = 0; i < 8; i++) begin
		fb = c[7] ^ b[i];
		c = (c << 1) ^ ({32{fb}} & t);
		if (!t[0]) c[0] = b[i];
	end
	return c & 32'hff;
endfunction
task automatic t_lfsr;
	bus(1'h1, ct, 32'h7);
	bus(1'h1, ta, 32'h107);
	bus(1'h1, dcs_pkg::DCS_OFF_DATA, 32'hdead);
	rdc(dcs_pkg::DCS_OFF_DATA, 32'h0);
	bus(1'h1, va, 32'hffffffff);
	rdc(va, 32'hff);
	put(8'ha5);
	rdc(va, step(32'hff, 32'h107, 8'ha5));
	rdc(ta, 32'h107);
	bus_s(1'h1, ta, 32'h0000ab00, 4'h2);
	rdc(ta, 32'h0000ab07);
endtask
task automatic t_csum;
	bus(1'h1, ct, 32'h8007);
	bus(1'h1, ta, 32'hffffffff);
	bus(1'h1, va, 32'h1234abcd);
	rdc(va, 32'habcd);
	put(8'h01);
	put(8'h02);
	rdc(va, 32'haacb);
	bus_s(1'h1, va, 32'h000000ee, 4'h1);
	rdc(va, 32'h0000aaee);
endtask
task automatic t_reset;
	sys_rst <= 1'h1;
	repeat (20) @(posedge ref_clk);
	sys_rst <= 1'h0;
	@(posedge ref_clk);
	rdc(va, 32'h0);
	rdc(ta, 32'h0);
	rdc(ct, 32'h0);
endtask
initial begin
	t_reset();
	t_lfsr();
	t_csum();
	t_reset();
	give_verdict();
end
endmodule
